// File: oww_watchdog.v
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "oww_map.vh"
module oww_watchdog #(
  parameter [31:0] OPTION_WORD = `OWW_OPT_DEFAULT
) (
  input  wire        i_clock,
  input  wire        i_sys_rst,
  input  wire        i_por_rst,
  input  wire        i_sleep,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output wire        o_irq,
  output wire        o_nmi,
  output wire        o_wdt_reset
);

  function [11:0] top_count;
    input [1:0] code;
    begin
      case (code)
        2'h0:    top_count = `OWW_TOP_128;
        2'h1:    top_count = `OWW_TOP_512;
        2'h2:    top_count = `OWW_TOP_1024;
        default: top_count = `OWW_TOP_2048;
      endcase
    end
  endfunction

  // unlisted divide codes fall back to divide by one
  function [7:0] div_max;
    input [3:0] code;
    begin
      case (code)
        `OWW_CKS_16:  div_max = `OWW_DIV_16;
        `OWW_CKS_32:  div_max = `OWW_DIV_32;
        `OWW_CKS_64:  div_max = `OWW_DIV_64;
        `OWW_CKS_128: div_max = `OWW_DIV_128;
        `OWW_CKS_256: div_max = `OWW_DIV_256;
        default:      div_max = `OWW_DIV_1;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      case (a)
        `OWW_OFF_REFRESH, `OWW_OFF_STATUS, `OWW_OFF_COUNT,
        `OWW_OFF_ISTAT, `OWW_OFF_ICLR, `OWW_OFF_IEN,
        `OWW_OFF_CCLR, `OWW_OFF_OPTION: mapped = 1'b1;
        default:                         mapped = 1'b0;
      endcase
    end
  endfunction

  // build-time image, upper half never reaches the logic
  localparam [31:0] OPT = OPTION_WORD & `OWW_OPT_MASK;
  localparam        AUTO_ON = ~OPT[`OWW_BIT_START];
  localparam [11:0] TOP = top_count(OPT[`OWW_TOP_LSB +: 2]);
  localparam [11:0] LOAD = TOP - 12'h001;
  localparam [7:0]  DIVM = div_max(OPT[`OWW_CKS_LSB +: 4]);
  localparam [1:0]  WEND = OPT[`OWW_WEND_LSB +: 2];
  localparam [1:0]  WBEG = OPT[`OWW_WBEG_LSB +: 2];
  localparam        ACT_RST = OPT[`OWW_BIT_ACTION];
  localparam        SLP_STOP = OPT[`OWW_BIT_STOP];
  localparam [11:0] QTR = TOP >> 2;
  localparam [11:0] HALF = TOP >> 1;
  localparam [11:0] TQTR = TOP - QTR;

  // window positions as remaining count
  localparam [11:0] FIN_POS = (WEND == 2'h0) ? TQTR :
                              (WEND == 2'h1) ? HALF :
                              (WEND == 2'h2) ? QTR  : 12'h000;
  localparam [11:0] BEG_POS = (WBEG == 2'h0) ? QTR  :
                              (WBEG == 2'h1) ? HALF :
                              (WBEG == 2'h2) ? TQTR : TOP;

  localparam [1:0] ST_STOP = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;
  localparam [1:0] ST_RST  = AUTO_ON ? ST_RUN : ST_STOP;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [11:0] count_q;
  reg  [11:0] count_d;
  reg  [7:0]  pre_q;
  reg  [7:0]  pre_d;
  reg         sleep_m_q;
  reg         sleep_s_q;
  reg  [1:0]  istat_q;
  reg  [1:0]  ien_q;
  reg         cause_q;
  reg         nmi_q;
  reg         wrst_q;
  reg  [31:0] prdata_q;
  reg  [31:0] rd_d;
  reg         err;
  reg         under;
  reg         rerr;

  wire        wr_acc = i_psel & i_penable & i_pwrite;
  wire        setup = i_psel & ~i_penable;
  wire        refresh = wr_acc & (i_paddr == `OWW_OFF_REFRESH);
  wire        iclr_wr = wr_acc & (i_paddr == `OWW_OFF_ICLR);
  wire        ien_wr = wr_acc & (i_paddr == `OWW_OFF_IEN);
  wire        cclr_wr = wr_acc & (i_paddr == `OWW_OFF_CCLR)
                        & i_pwdata[`OWW_CCLR_BIT];
  wire        running = state_q[1];
  wire        halted = SLP_STOP & sleep_s_q;
  wire        tick = running & ~halted & (pre_q == DIVM);
  wire        in_win = (count_q <= BEG_POS) & (count_q >= FIN_POS);
  wire [1:0]  ev;

  // sleep arrives from the power controller, another domain
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_m_q <= 1'b0;
      sleep_s_q <= 1'b0;
    end else begin
      sleep_m_q <= i_sleep;
      sleep_s_q <= sleep_m_q;
    end
  end

  always @* begin
    state_d = state_q;
    count_d = count_q;
    pre_d = pre_q;
    under = 1'b0;
    rerr = 1'b0;
    case (state_q)
      ST_STOP: begin
        pre_d = 8'h00;
        // a refresh while stopped is the register start
        if (refresh) begin
          state_d = ST_RUN;
          count_d = LOAD;
        end
      end
      ST_RUN: begin
        if (refresh) begin
          pre_d = 8'h00;
          if (in_win) begin
            count_d = LOAD;
          end else begin
            rerr = 1'b1;
          end
        end else if (!halted) begin
          pre_d = tick ? 8'h00 : pre_q + 8'h01;
          if (tick) begin
            if (count_q == 12'h000) begin
              under = 1'b1;
            end else begin
              count_d = count_q - 12'h001;
            end
          end
        end
        // counting halts after an error until next refresh
        if (under | rerr) begin
          state_d = ST_STOP;
          count_d = LOAD;
        end
      end
      default: begin
        state_d = ST_STOP;
        count_d = LOAD;
        pre_d = 8'h00;
      end
    endcase
    err = under | rerr;
  end

  assign ev = {rerr, under};

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_RST;
      count_q <= LOAD;
      pre_q <= 8'h00;
      nmi_q <= 1'b0;
      wrst_q <= 1'b0;
      istat_q <= 2'h0;
      ien_q <= 2'h0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      pre_q <= pre_d;
      nmi_q <= err & ~ACT_RST;
      wrst_q <= err & ACT_RST;
      // new events win over a clear in the same cycle
      istat_q <= (istat_q & ~({2{iclr_wr}} & i_pwdata[1:0])) | ev;
      if (ien_wr) begin
        ien_q <= i_pwdata[1:0];
      end
    end
  end

  // cause flag survives the system reset it provoked
  always @(posedge i_clock or posedge i_por_rst) begin
    if (i_por_rst) begin
      cause_q <= 1'b0;
    end else if (err & ACT_RST) begin
      cause_q <= 1'b1;
    end else if (cclr_wr) begin
      cause_q <= 1'b0;
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    case (i_paddr)
      `OWW_OFF_STATUS: begin
        rd_d[`OWW_ST_RUN] = running;
        rd_d[`OWW_ST_CAUSE] = cause_q;
      end
      `OWW_OFF_COUNT:  rd_d[11:0] = count_q;
      `OWW_OFF_ISTAT:  rd_d[1:0] = istat_q;
      `OWW_OFF_IEN:    rd_d[1:0] = ien_q;
      `OWW_OFF_OPTION: rd_d = OPT;
      default:         rd_d = 32'h00000000;
    endcase
  end

  // read data sampled in setup so pready can stay high
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= rd_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);
  assign o_irq = |(istat_q & ien_q);
  assign o_nmi = nmi_q;
  assign o_wdt_reset = wrst_q;

endmodule

// File: oww_map.vh
`ifndef OWW_MAP_VH
`define OWW_MAP_VH

`define OWW_OFF_REFRESH 12'h000
`define OWW_OFF_STATUS  12'h004
`define OWW_OFF_COUNT   12'h008
`define OWW_OFF_ISTAT   12'h00C
`define OWW_OFF_ICLR    12'h010
`define OWW_OFF_IEN     12'h014
`define OWW_OFF_CCLR    12'h018
`define OWW_OFF_OPTION  12'h400

`define OWW_OPT_DEFAULT 32'h0000BF09
`define OWW_OPT_MASK    32'h0000FFFF
`define OWW_BIT_START   1
`define OWW_TOP_LSB     2
`define OWW_CKS_LSB     4
`define OWW_WEND_LSB    8
`define OWW_WBEG_LSB    10
`define OWW_BIT_ACTION  12
`define OWW_BIT_STOP    14

`define OWW_TOP_128     12'h080
`define OWW_TOP_512     12'h200
`define OWW_TOP_1024    12'h400
`define OWW_TOP_2048    12'h800

`define OWW_CKS_1       4'h0
`define OWW_CKS_16      4'h2
`define OWW_CKS_32      4'h3
`define OWW_CKS_64      4'h4
`define OWW_CKS_128     4'hF
`define OWW_CKS_256     4'h5
`define OWW_DIV_1       8'h00
`define OWW_DIV_16      8'h0F
`define OWW_DIV_32      8'h1F
`define OWW_DIV_64      8'h3F
`define OWW_DIV_128     8'h7F
`define OWW_DIV_256     8'hFF

`define OWW_WIN_NONE    2'h3
`define OWW_EV_UNDER    0
`define OWW_EV_RERR     1
`define OWW_ST_RUN      0
`define OWW_ST_CAUSE    1
`define OWW_CCLR_BIT    0

`endif

// File: oww_watchdog_sva.sv
`timescale 1ns/1ns
module oww_watchdog_chk #(
  parameter [31:0] OPTION_WORD = 32'h00000000
) (
  input wire        i_clock,
  input wire        i_sys_rst,
  input wire        i_por_rst,
  input wire        i_sleep,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        o_irq,
  input wire        o_nmi,
  input wire        o_wdt_reset
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire rd_setup = i_psel && !i_penable && !i_pwrite;
  wire acc      = i_psel && i_penable;
  a_ready_high: assert property (o_pready) else $error("not ready");
  a_unmapped_err: assert property (acc && i_paddr == 12'h0FC
    |-> o_pslverr) else $error("no error on hole");
  a_option_ok: assert property (acc && i_paddr == 12'h400 |-> !o_pslverr)
    else $error("error on option");
  a_option_value: assert property (rd_setup && i_paddr == 12'h400
    |=> o_prdata == (OPTION_WORD & 32'h0000FFFF)) else $error("option");
  a_hole_zero: assert property (rd_setup && i_paddr == 12'h0FC
    |=> o_prdata == 32'h00000000) else $error("hole data");
  a_count_width: assert property (rd_setup && i_paddr == 12'h008
    |=> o_prdata[31:12] == 20'h00000) else $error("count width");
  a_nmi_pulse: assert property ($rose(o_nmi) |=> !o_nmi)
    else $error("nmi too long");
  a_rst_pulse: assert property (o_wdt_reset |=> !o_wdt_reset)
    else $error("reset too long");
  a_action_sel: assert property (!(OPTION_WORD[12] ? o_nmi
    : o_wdt_reset)) else $error("wrong action");
  // irq may only rise with an error pulse or right after an enable write
  a_irq_source: assert property ($rose(o_irq) |-> o_nmi || o_wdt_reset
    || $past(acc && i_pwrite && i_paddr == 12'h014)) else $error("irq src");
endmodule
bind oww_watchdog oww_watchdog_chk #(.OPTION_WORD(OPTION_WORD)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_por_rst(i_por_rst),
  .i_sleep(i_sleep), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_irq(o_irq), .o_nmi(o_nmi), .o_wdt_reset(o_wdt_reset));

// File: option_word_window_watchdog_test.sv
`timescale 1ns/1ns
module option_word_window_watchdog_test;
  // 128 ticks, div 1, window 96..64, nmi, stop in sleep; junk upper half
  localparam [31:0] OPT = 32'hA5A5E901;
  // second unit: manual start, 128 ticks, div 16, no window, reset action
  localparam [31:0] OPT2 = 32'h0000BF23;
  logic        clk = 0, rst = 1, por = 1, slp = 0, psel = 0, pen = 0, pwr = 0;
  logic        psel2 = 0, rst2 = 1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h00000000, rd;
  wire  [31:0] prdata, prdata2;
  wire         pready, pslverr, irq, nmi, wrst;
  wire         pready2, pslverr2, irq2, nmi2, wrst2;
  int          errors = 0, n_compared = 0, n_nmi = 0, n_rst = 0, c;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t mismatch %h %h", $time, a, b); end end
  oww_watchdog #(.OPTION_WORD(OPT)) DUT (
    .i_clock(clk), .i_sys_rst(rst), .i_por_rst(por), .i_sleep(slp),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq), .o_nmi(nmi), .o_wdt_reset(wrst));
  oww_watchdog #(.OPTION_WORD(OPT2)) DUT2 (
    .i_clock(clk), .i_sys_rst(rst2), .i_por_rst(por), .i_sleep(slp),
    .i_psel(psel2), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wd), .o_prdata(prdata2), .o_pready(pready2),
    .o_pslverr(pslverr2), .o_irq(irq2), .o_nmi(nmi2), .o_wdt_reset(wrst2));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (nmi === 1'b1) n_nmi++;
  always @(posedge clk) if (wrst2 === 1'b1) n_rst++;
  function int top(input logic [1:0] code);
    return (code == 2'h0) ? 128 : (256 << code);
  endfunction
  function int div(input logic [3:0] code);
    case (code)
      4'h2: return 16;
      4'h3: return 32;
      4'h4: return 64;
      4'hF: return 128;
      4'h5: return 256;
      default: return 1;
    endcase
  endfunction
  // open span as remaining count, begin and finish taken from the word
  function automatic bit win_ok(input int cnt);
    int t = top(OPT[3:2]);
    int b = (OPT[11:10] == 2'h3) ? t : t * (OPT[11:10] + 1) / 4;
    int f = (OPT[9:8] == 2'h3) ? 0 : t * (3 - OPT[9:8]) / 4;
    return cnt <= b && cnt >= f;
  endfunction
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
           input bit t = 1'b0);
    @(posedge clk);
    psel <= !t; psel2 <= t; pen <= 0; pwr <= w; addr <= a; wd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while ((t ? pready2 : pready) !== 1'b1) @(posedge clk);
    rd = t ? prdata2 : prdata;
    psel <= 0; psel2 <= 0; pen <= 0;
  endtask
  // refresh the first unit so that it lands at remaining count tgt
  task win(input int tgt);
    int k;
    k = n_nmi;
    bus(0, 12'h008, 0);
    c = rd[11:0];
    idle(c - 4 - tgt);
    bus(1, 12'h000, $urandom);
    idle(2);
    `CHK(n_nmi - k, win_ok(tgt) ? 0 : 1)
    if (!win_ok(tgt)) bus(1, 12'h000, 0);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task complete_run;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(50652));
    idle(5);
    rst <= 0; rst2 <= 0; por <= 0;
    bus(0, 12'h400, 0); `CHK(rd, OPT & 32'h0000FFFF)
    bus(0, 12'h004, 0); `CHK(rd[1:0], {1'b0, ~OPT[1]})
    bus(0, 12'h0FC, 0); `CHK(rd, 32'h00000000)
    bus(1, 12'h014, 32'h2);
    // refresh well inside the window with random jitter
    repeat (5) win(69 + $urandom % 16);
    idle(3); `CHK(n_nmi, 0)
    bus(1, 12'h000, 0); idle(3); `CHK(n_nmi, 1)
    bus(0, 12'h00C, 0); `CHK(rd[1:0], 2'b10)
    `CHK(irq, 1'b1)
    bus(0, 12'h004, 0); `CHK(rd[1:0], 2'b00)
    bus(1, 12'h010, 32'h3); idle(1); `CHK(irq, 1'b0)
    bus(1, 12'h000, 0); idle(top(OPT[3:2]) + 12);
    `CHK(n_nmi, 2)
    bus(0, 12'h00C, 0); `CHK(rd[1:0], 2'b01)
    `CHK(irq, 1'b0)
    // sleep is synchronised, so give it a few cycles to land
    bus(1, 12'h000, 0); slp <= 1; idle(4);
    bus(0, 12'h008, 0); c = rd[11:0]; idle(20);
    bus(0, 12'h008, 0); `CHK(rd[11:0], c[11:0])
    slp <= 0; idle(6);
    bus(0, 12'h008, 0); `CHK(rd[11:0] < c[11:0], 1'b1)
    // both window edges and one past each, then random counts from 60 to 100
    win(96); win(97); win(64); win(63);
    repeat (6) win(60 + $urandom % 41);
    // manual start unit: stays stopped until the first refresh
    bus(0, 12'h004, 0, 1); `CHK(rd[1:0], {1'b0, ~OPT2[1]})
    idle(40);
    bus(0, 12'h008, 0, 1); `CHK(rd[11:0], top(OPT2[3:2]) - 1)
    bus(1, 12'h000, 0, 1);
    idle(top(OPT2[3:2]) * div(OPT2[7:4]) - 8); `CHK(n_rst, 0)
    idle(16); `CHK(n_rst, 1)
    bus(0, 12'h004, 0, 1); `CHK(rd[1:0], 2'b10)
    bus(1, 12'h014, 32'h1, 1); idle(1); `CHK(irq2, 1'b1)
    // cause flag must outlive a system reset
    rst2 <= 1; idle(2); rst2 <= 0;
    bus(0, 12'h004, 0, 1); `CHK(rd[1:0], 2'b10)
    `CHK(irq2, 1'b0)
    bus(1, 12'h018, 32'h1, 1);
    bus(0, 12'h004, 0, 1); `CHK(rd[1:0], 2'b00)
    complete_run;
  end
endmodule
